/* rtl/pll_div_cfg.svh */
// register map, field positions, reset values and limits of the divider network
// What this block does
// - half duty dividers take 1 to 512
// - other duty dividers take 1 to 256
// - finest phase step is VCO period over eight
// - every output except cascaded divider one shifts in 45 degree steps
// - optional halving divider after the oscillator
// - only divider zero drives the dedicated output
// - dividers one, two, three feed transceiver clocks
// - one dedicated output, single-ended or differential
// - differential legs are complementary, one inverted
// - single-ended: spare pin works as user I/O
// - reference selectable from four same-side pins
// - up to five feedback compensation modes
// - simpler variant offers four feedback modes
// - source-synchronous keeps data/clock phase at registers
// - source-synchronous compensates network and pin path mismatch
// - pre-divider and multiplier take 1 to 512
// - divide value is high plus low count
// - cascaded dividers multiply their settings
// - duty resolution is one over divide value
`ifndef PLL_DIV_CFG_SVH
`define PLL_DIV_CFG_SVH
`define ADDR_CTRL 12'h000
`define ADDR_LOOPDIV 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CNT_BASE 12'h010
`define CTRL_RUN 0
`define CTRL_VCO_HALF 1
`define CTRL_FB_LSB 2
`define CTRL_REF_LSB 5
`define CTRL_CLKOUT_EN 7
`define CTRL_DIFF 8
`define CTRL_CASCADE 9
`define CTRL_IO_OE 10
`define CTRL_IO_OUT 11
`define LOOP_N_LSB 0
`define LOOP_M_LSB 16
`define ST_LOCKED 0
`define ST_RUNNING 1
`define ST_CFG_ERR 2
`define ST_NEG_PIN 3
`define CNT_HI_LSB 0
`define CNT_LO_LSB 9
`define CNT_TAP_LSB 18
`define CNT_DLY_LSB 21
`define FB_MODE_RST 3'h2
`define REF_SEL_RST 2'h0
`define LOOP_DIV_RST 10'h001
`define CNT_CFG_RST 30'h0000_0201
`define DIV_MAX_HALF 10'h0200
`define DIV_MAX_OTHER 10'h0100
`define LOOP_DIV_MAX 10'h0200
`define PHASE_TAP_LAST 3'h7
`endif

/* rtl/pll_div_pkg.sv */
// types shared by the divider network files
package pll_div_pkg;
	typedef enum logic [2:0] {
		fb_src_sync = 3'h0,
		fb_no_comp = 3'h1,
		fb_normal = 3'h2,
		fb_zero_delay_buffer_mode = 3'h3,
		fb_det_latency = 3'h4
	} fb_mode_t;
	typedef enum logic [2:0] {st_hold = 3'b001, st_wait_lock = 3'b010, st_run = 3'b100} run_state_t;
	typedef struct packed {
		logic [8:0] delay;
		logic [2:0] tap;
		logic [8:0] low;
		logic [8:0] high;
	} div_cfg_t;
	typedef struct packed {
		logic clk;
		logic rise;
	} div_line_t;
	typedef struct packed {
		logic [8:0] dly;
		logic [8:0] pos;
		logic clk;
		logic rise;
	} div_state_t;
	typedef struct packed {
		logic serial;
		logic load_en;
		logic parallel;
	} tx_clk_t;
	typedef struct packed {
		fb_mode_t fb_mode;
		logic io_path_fb;
		logic [3:0] ref_pin_sel;
		logic [9:0] pre_div;
		logic [9:0] mult_div;
	} loop_ctrl_t;
	typedef struct packed {
		run_state_t fsm;
		logic run;
		logic vco_half;
		fb_mode_t fb_mode;
		logic [1:0] ref_sel;
		logic clkout_en;
		logic diff_out;
		logic cascade;
		logic io_oe;
		logic io_out;
		logic [9:0] pre_div;
		logic [9:0] mult_div;
		div_cfg_t [4:0] cfg;
		div_cfg_t [4:0] act;
		logic act_half;
		logic act_casc;
		logic [2:0] ph;
		logic kph;
		logic [2:0] lock_sync;
		logic locked;
		logic [2:0] io_sync;
		logic io_in;
		logic cfg_err;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pin_pos;
		logic pin_pos_oe;
		logic pin_neg;
		logic pin_neg_oe;
	} nw_state_t;
endpackage

/* rtl/post_scale_counter.sv */
// one post-scale output divider with start delay and high/low counts
`timescale 1ns/1ns
`default_nettype none
`include "pll_div_cfg.svh"

module post_scale_counter (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic tick,
	input wire pll_div_pkg::div_cfg_t cfg,
	// divided clock
	output pll_div_pkg::div_line_t line
);
	import pll_div_pkg::*;

	localparam div_state_t DIV_RESET = '{default: '0};
	div_state_t s_reg;
	div_state_t s_next;
	logic [9:0] total;
	logic lvl;

	// divide value and the level of the current position
	assign total = 10'({1'b0, cfg.high} + {1'b0, cfg.low});
	assign lvl = (s_reg.pos < cfg.high);

	// held cleared with the start delay loaded while stopped, one step per tick otherwise
	always_comb begin
		s_next = s_reg;
		s_next.rise = 1'b0;
		if (!run) begin
			s_next = DIV_RESET;
			s_next.dly = cfg.delay;
		end else if (tick) begin
			if (s_reg.dly != 9'h000) begin
				s_next.dly = s_reg.dly - 9'h001;
			end else begin
				s_next.clk = lvl;
				s_next.rise = lvl && (!s_reg.clk || cfg.low == 9'h000);
				if ((10'({1'b0, s_reg.pos}) + 10'h001) >= total) begin
					s_next.pos = 9'h000;
				end else begin
					s_next.pos = s_reg.pos + 9'h001;
				end
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= DIV_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign line.clk = s_reg.clk;
	assign line.rise = s_reg.rise;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// level follows the high/low split of the divide value
	duty_count_a: assert property (run && tick && s_reg.dly == 9'h000 |=>
		line.clk == ($past(s_reg.pos) < $past(cfg.high)))
		else $error("divider level does not follow high count");
	start_delay_a: assert property (run && s_reg.dly != 9'h000 |-> !line.clk)
		else $error("divider output high during start delay");
endmodule
`default_nettype wire

/* rtl/pll_output_divider_network.sv */
// divider network top: apb registers, phase taps, start sequencing, clock pins
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pll_div_cfg.svh"

module pll_output_divider_network #(
	parameter int NUM_DIV = 5,
	parameter bit SIMPLE_VARIANT = 1'b0
) (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog loop
	input wire logic loop_locked,
	output pll_div_pkg::loop_ctrl_t loop_ctrl,
	// divided clocks
	output logic [NUM_DIV-1:0] global_clock_network,
	output pll_div_pkg::tx_clk_t tx_clocks,
	// dedicated output pin pair
	output logic dedicated_clock_out_pos,
	output logic dedicated_clock_out_pos_oe,
	input wire logic dedicated_clock_out_neg_in,
	output logic dedicated_clock_out_neg,
	output logic dedicated_clock_out_neg_oe
);
	import pll_div_pkg::*;

	localparam nw_state_t NW_RESET = '{
		fsm: st_hold,
		fb_mode: fb_mode_t'(`FB_MODE_RST),
		ref_sel: `REF_SEL_RST,
		pre_div: `LOOP_DIV_RST,
		mult_div: `LOOP_DIV_RST,
		cfg: {5{`CNT_CFG_RST}},
		act: {5{`CNT_CFG_RST}},
		kph: 1'b1,
		default: '0
	};

	// the map has five divider slots; transceiver clocks need four
	if (NUM_DIV < 4 || NUM_DIV > 5) begin : g_bad_num
		$error("NUM_DIV must be 4 or 5");
	end

	nw_state_t st_reg;
	nw_state_t st_next;
	logic running;
	logic [NUM_DIV-1:0] tap_hit;
	logic [NUM_DIV-1:0] tick;
	logic [NUM_DIV-1:0] cfg_ok;
	div_line_t [NUM_DIV-1:0] line;
	logic is_cnt;
	logic acc_ok;
	logic wr_final;
	logic [11:0] cnt_off;
	logic [2:0] idx;
	logic [2:0] wfb;
	div_cfg_t wcfg;
	logic [9:0] wn;
	logic [9:0] wm;
	logic [31:0] rd_word;

	// divider setting fits its duty class
	function automatic logic cnt_ok(input div_cfg_t c);
		logic [9:0] tot;
		logic half;
		tot = 10'({1'b0, c.high} + {1'b0, c.low});
		half = (c.high == c.low) || (10'({1'b0, c.high}) == 10'({1'b0, c.low}) + 10'h001);
		return (c.high != 9'h000) && (tot <= (half ? `DIV_MAX_HALF : `DIV_MAX_OTHER));
	endfunction

	// loop divider value in range
	function automatic logic loop_ok(input logic [9:0] v);
		return (v != 10'h000) && (v <= `LOOP_DIV_MAX);
	endfunction

	assign running = (st_reg.fsm == st_run);

	// one tap per divider, cascade feeds divider one from divider zero
	for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
		assign tap_hit[i] = running && (st_reg.ph == st_reg.act[i].tap) && (!st_reg.act_half || st_reg.kph);
		if (i == 1) begin : g_casc
			assign tick[i] = st_reg.act_casc ? line[0].rise : tap_hit[i];
		end else begin : g_tap
			assign tick[i] = tap_hit[i];
		end
		assign cfg_ok[i] = cnt_ok(st_reg.cfg[i]);
		post_scale_counter u_cnt (
			.pclk(pclk),
			.presetn(presetn),
			.run(running),
			.tick(tick[i]),
			.cfg(st_reg.act[i]),
			.line(line[i])
		);
		assign global_clock_network[i] = line[i].clk;
	end

	// next state: synchronisers, start sequence, taps, apb, pins
	always_comb begin
		st_next = st_reg;
		cnt_off = paddr - `ADDR_CNT_BASE;
		idx = cnt_off[4:2];
		is_cnt = (paddr >= `ADDR_CNT_BASE) && (cnt_off[11:2] < 10'(NUM_DIV));
		wfb = pwdata[`CTRL_FB_LSB +: 3];
		wn = pwdata[`LOOP_N_LSB +: 10];
		wm = pwdata[`LOOP_M_LSB +: 10];
		wcfg.high = pwdata[`CNT_HI_LSB +: 9];
		wcfg.low = pwdata[`CNT_LO_LSB +: 9];
		wcfg.tap = pwdata[`CNT_TAP_LSB +: 3];
		wcfg.delay = pwdata[`CNT_DLY_LSB +: 9];
		rd_word = 32'h0000_0000;
		acc_ok = 1'b0;
		wr_final = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
		// lock and spare pin: third and second stage must agree
		st_next.lock_sync = {st_reg.lock_sync[1:0], loop_locked};
		if (st_reg.lock_sync[2] == st_reg.lock_sync[1]) begin
			st_next.locked = st_reg.lock_sync[2];
		end
		st_next.io_sync = {st_reg.io_sync[1:0], dedicated_clock_out_neg_in};
		if (st_reg.io_sync[2] == st_reg.io_sync[1]) begin
			st_next.io_in = st_reg.io_sync[2];
		end
		// start sequence: settings are copied while stopped, so taps never move mid-run
		case (st_reg.fsm)
			st_hold: begin
				st_next.act = st_reg.cfg;
				st_next.act_half = st_reg.vco_half;
				st_next.act_casc = st_reg.cascade;
				if (st_reg.run) begin
					st_next.fsm = st_wait_lock;
				end
			end
			st_wait_lock: begin
				st_next.act = st_reg.cfg;
				st_next.act_half = st_reg.vco_half;
				st_next.act_casc = st_reg.cascade;
				if (!st_reg.run) begin
					st_next.fsm = st_hold;
				end else if (st_reg.locked) begin
					st_next.fsm = st_run;
				end
			end
			st_run: begin
				if (!st_reg.run || !st_reg.locked) begin
					st_next.fsm = st_hold;
				end
			end
			default: begin
				st_next.fsm = st_hold;
			end
		endcase
		// eight taps per oscillator period, halving toggles each period
		if (running) begin
			st_next.ph = st_reg.ph + 3'h1;
			if (st_reg.ph == `PHASE_TAP_LAST) begin
				st_next.kph = ~st_reg.kph;
			end
		end else begin
			st_next.ph = 3'h0;
			st_next.kph = 1'b1;
		end
		// apb decode and read data
		if (paddr[1:0] != 2'h0) begin
			acc_ok = 1'b0;
		end else if (paddr == `ADDR_CTRL) begin
			rd_word[`CTRL_RUN] = st_reg.run;
			rd_word[`CTRL_VCO_HALF] = st_reg.vco_half;
			rd_word[`CTRL_FB_LSB +: 3] = st_reg.fb_mode;
			rd_word[`CTRL_REF_LSB +: 2] = st_reg.ref_sel;
			rd_word[`CTRL_CLKOUT_EN] = st_reg.clkout_en;
			rd_word[`CTRL_DIFF] = st_reg.diff_out;
			rd_word[`CTRL_CASCADE] = st_reg.cascade;
			rd_word[`CTRL_IO_OE] = st_reg.io_oe;
			rd_word[`CTRL_IO_OUT] = st_reg.io_out;
			acc_ok = !pwrite || (wfb <= 3'(fb_det_latency) && !(SIMPLE_VARIANT && wfb == 3'(fb_det_latency)));
		end else if (paddr == `ADDR_LOOPDIV) begin
			rd_word[`LOOP_N_LSB +: 10] = st_reg.pre_div;
			rd_word[`LOOP_M_LSB +: 10] = st_reg.mult_div;
			acc_ok = !pwrite || (loop_ok(wn) && loop_ok(wm));
		end else if (paddr == `ADDR_STATUS) begin
			rd_word[`ST_LOCKED] = st_reg.locked;
			rd_word[`ST_RUNNING] = running;
			rd_word[`ST_CFG_ERR] = st_reg.cfg_err;
			rd_word[`ST_NEG_PIN] = st_reg.io_in;
			acc_ok = 1'b1;
		end else if (is_cnt) begin
			rd_word = {2'h0, st_reg.cfg[idx]};
			acc_ok = !pwrite || cnt_ok(wcfg);
		end
		// answer one cycle into the access phase
		st_next.pready = psel && penable && !st_reg.pready;
		if (psel && penable && !st_reg.pready) begin
			st_next.prdata = rd_word;
			st_next.pslverr = !acc_ok;
		end
		// writes land at the edge that completes the transfer
		if (wr_final && paddr == `ADDR_CTRL) begin
			st_next.run = pwdata[`CTRL_RUN];
			st_next.vco_half = pwdata[`CTRL_VCO_HALF];
			st_next.fb_mode = fb_mode_t'(wfb);
			st_next.ref_sel = pwdata[`CTRL_REF_LSB +: 2];
			st_next.clkout_en = pwdata[`CTRL_CLKOUT_EN];
			st_next.diff_out = pwdata[`CTRL_DIFF];
			st_next.cascade = pwdata[`CTRL_CASCADE];
			st_next.io_oe = pwdata[`CTRL_IO_OE];
			st_next.io_out = pwdata[`CTRL_IO_OUT];
		end
		if (wr_final && paddr == `ADDR_LOOPDIV) begin
			st_next.pre_div = wn;
			st_next.mult_div = wm;
		end
		if (wr_final && is_cnt && paddr[1:0] == 2'h0) begin
			st_next.cfg[idx] = wcfg;
		end
		// error flag: write one clears, a refused write sets and wins
		if (wr_final && paddr == `ADDR_STATUS && pwdata[`ST_CFG_ERR]) begin
			st_next.cfg_err = 1'b0;
		end
		if (psel && penable && st_reg.pready && pwrite && st_reg.pslverr) begin
			st_next.cfg_err = 1'b1;
		end
		// dedicated pins: divider zero only, neg leg inverted or user I/O
		st_next.pin_pos = st_reg.clkout_en && line[0].clk;
		st_next.pin_pos_oe = st_reg.clkout_en;
		if (st_reg.clkout_en && st_reg.diff_out) begin
			st_next.pin_neg = !(st_reg.clkout_en && line[0].clk);
			st_next.pin_neg_oe = 1'b1;
		end else begin
			st_next.pin_neg = st_reg.io_out;
			st_next.pin_neg_oe = st_reg.io_oe;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= NW_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pready && st_reg.pslverr;
	assign loop_ctrl.fb_mode = st_reg.fb_mode;
	assign loop_ctrl.io_path_fb = (st_reg.fb_mode == fb_src_sync);
	assign loop_ctrl.ref_pin_sel = 4'(4'h1 << st_reg.ref_sel);
	assign loop_ctrl.pre_div = st_reg.pre_div;
	assign loop_ctrl.mult_div = st_reg.mult_div;
	assign tx_clocks.serial = line[1].clk;
	assign tx_clocks.load_en = line[2].clk;
	assign tx_clocks.parallel = line[3].clk;
	assign dedicated_clock_out_pos = st_reg.pin_pos;
	assign dedicated_clock_out_pos_oe = st_reg.pin_pos_oe;
	assign dedicated_clock_out_neg = st_reg.pin_neg;
	assign dedicated_clock_out_neg_oe = st_reg.pin_neg_oe;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	div_range_a: assert property (&cfg_ok)
		else $error("stored divider setting out of range");
	narrow_refuse_a: assert property (psel && penable && !pready && pwrite && is_cnt &&
		wcfg.low == 9'h000 && wcfg.high > 9'h100 |=> pready && pslverr)
		else $error("uneven divider above 256 accepted");
	tap_period_a: assert property (tap_hit[0] && !st_reg.act_half |-> ##8 (tap_hit[0] || !running))
		else $error("tap does not repeat every eight cycles");
	tap_offset_a: assert property (tap_hit[0] && st_reg.act[1].tap == st_reg.act[0].tap + 3'h1 &&
		!st_reg.act_casc |=> tap_hit[1] || !running)
		else $error("adjacent tap not one step later");
	vco_half_a: assert property (tap_hit[0] && st_reg.act_half |->
		##8 !tap_hit[0] ##8 (tap_hit[0] || !running))
		else $error("halved oscillator period wrong");
	clkout_src_a: assert property (dedicated_clock_out_pos_oe |-> dedicated_clock_out_pos == $past(line[0].clk))
		else $error("dedicated output not from divider zero");
	tx_map_a: assert property (tx_clocks == {line[1].clk, line[2].clk, line[3].clk})
		else $error("transceiver clock mapping wrong");
	diff_pair_a: assert property (st_reg.clkout_en && st_reg.diff_out |=>
		dedicated_clock_out_neg == !dedicated_clock_out_pos && dedicated_clock_out_neg_oe)
		else $error("differential legs not complementary");
	single_end_a: assert property (!st_reg.diff_out |=>
		dedicated_clock_out_neg == $past(st_reg.io_out) && dedicated_clock_out_neg_oe == $past(st_reg.io_oe))
		else $error("spare pin not driven as user io");
	ref_sel_a: assert property ($onehot(loop_ctrl.ref_pin_sel))
		else $error("reference select not one of four");
	fb_mode_a: assert property (3'(loop_ctrl.fb_mode) <= 3'(fb_det_latency) &&
		!(SIMPLE_VARIANT && loop_ctrl.fb_mode == fb_det_latency))
		else $error("illegal feedback mode held");
	loop_div_a: assert property (loop_ok(st_reg.pre_div) && loop_ok(st_reg.mult_div))
		else $error("loop divider out of range");
	hold_lock_a: assert property (!st_reg.locked |-> ##2 global_clock_network == '0)
		else $error("divider running without lock");

	cover_run_c: cover property (running && line[0].rise);
	cover_casc_c: cover property (running && st_reg.act_casc && line[1].rise);
	cover_diff_c: cover property (dedicated_clock_out_neg_oe && st_reg.diff_out && dedicated_clock_out_pos);
	cover_refuse_c: cover property (pready && pslverr && pwrite);
endmodule
`default_nettype wire

/* test/loop_partner.sv */
// analog loop and pin-side model: lock after a settle time, level of the negative pin
`timescale 1ns/1ns
`default_nettype none
module loop_partner #(
	parameter int LOCK_DLY = 20
) (
	// clock
	input wire logic pclk,
	// loop side
	input wire logic lock_en,
	input wire logic [3:0] ref_pin_sel,
	output logic loop_locked,
	// negative pin drivers and resolved level
	input wire logic neg,
	input wire logic neg_oe,
	input wire logic ext_val,
	input wire logic ext_oe,
	output logic neg_in
);
	int cnt = 0;
	logic lk = 1'b0;
	logic flt = 1'b0;
	// lock only with exactly one pin-fed reference selected
	always @(posedge pclk) begin
		cnt <= (lock_en && $onehot(ref_pin_sel)) ? cnt + 1 : 0;
		lk <= (cnt >= LOCK_DLY);
		flt <= ~flt;
	end
	assign loop_locked = lk;
	// an undriven pin wanders, so a stale level never passes for a read
	assign neg_in = neg_oe ? neg : (ext_oe ? ext_val : flt);
endmodule
`default_nettype wire

/* test/tb_pll_output_divider_network.sv */
// self-checking bench for the divider network: apb tasks, limits, modes, run sequences
`timescale 1ns/1ns
`default_nettype none
`include "pll_div_cfg.svh"
module tb_pll_output_divider_network;
	import pll_div_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, loop_locked, pos, pos_oe, neg, neg_oe, neg_in;
	loop_ctrl_t loop_ctrl;
	tx_clk_t tx_clocks;
	logic [4:0] gcn;
	logic [6:0] obs;
	logic lock_en = 1'b0, ext_val = 1'b0, ext_oe = 1'b1, mon_en = 1'b0, prev0 = 1'b0;
	int err_count = 0;
	int compares = 0;
	pll_output_divider_network #(.NUM_DIV(5), .SIMPLE_VARIANT(1'b0)) u_pll_output_divider_network (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_locked(loop_locked),
		.loop_ctrl(loop_ctrl), .global_clock_network(gcn), .tx_clocks(tx_clocks),
		.dedicated_clock_out_pos(pos), .dedicated_clock_out_pos_oe(pos_oe), .dedicated_clock_out_neg_in(neg_in),
		.dedicated_clock_out_neg(neg), .dedicated_clock_out_neg_oe(neg_oe));
	loop_partner #(.LOCK_DLY(20)) u_loop_partner (.pclk(pclk), .lock_en(lock_en), .ref_pin_sel(loop_ctrl.ref_pin_sel),
		.loop_locked(loop_locked), .neg(neg), .neg_oe(neg_oe), .ext_val(ext_val), .ext_oe(ext_oe), .neg_in(neg_in));
	assign obs = {neg, pos, gcn};
	// clock
	always #4 pclk = ~pclk;
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) err_count++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		check({31'h0000_0000, e}, {31'h0000_0000, ee});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check({31'h0000_0000, e}, {31'h0000_0000, ee});
		if (!ee) check(q, exp);
	endtask
	function automatic logic [31:0] cw(input int h, input int l, input int t);
		return 32'((t << 18) | (l << 9) | h);
	endfunction
	// poll status until the dividers run
	task automatic wait_run();
		logic [31:0] q;
		logic e;
		int n;
		n = 0;
		q = 32'h0000_0000;
		while (q[1] !== 1'b1 && n < 40) begin
			apb(1'b0, `ADDR_STATUS, 32'h0000_0000, q, e);
			n++;
		end
		check(q & 32'h0000_0007, 32'h0000_0003);
	endtask
	// bounded wait for a level on an observed clock
	task automatic wt(input int b, input logic v);
		int n;
		n = 0;
		while (obs[b] !== v && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 4000) err_count++;
	endtask
	// period and high time of one observed clock, in pclk cycles
	task automatic mchk(input int b, input int ep, input int eh);
		int p, h;
		p = 0;
		h = 0;
		wt(b, 1'b0);
		wt(b, 1'b1);
		while (obs[b] === 1'b1 && p < 4000) begin
			h++;
			p++;
			@(posedge pclk);
		end
		while (obs[b] !== 1'b1 && p < 4000) begin
			p++;
			@(posedge pclk);
		end
		check(p, ep);
		check(h, eh);
	endtask
	// cycles from a rise of clock a to the next rise of clock b
	task automatic ochk(input int a, input int b, input int exp);
		int n;
		n = 0;
		wt(a, 1'b0);
		wt(a, 1'b1);
		while (obs[b] !== 1'b1 && n < 4000) begin
			n++;
			@(posedge pclk);
		end
		check(n, exp);
	endtask
	// pin and transceiver routing while dividers run
	always @(posedge pclk) begin
		if (mon_en) begin
			check({tx_clocks.serial, tx_clocks.load_en, tx_clocks.parallel}, {gcn[1], gcn[2], gcn[3]});
			check(pos, prev0);
			check(neg, {~pos});
		end
		prev0 <= gcn[0];
	end
	// watchdog
	initial begin
		#240000;
		err_count++;
		finish_test();
	end
	// main sequence
	initial begin
		int hv[6];
		int lv[6];
		logic [31:0] last;
		hv = '{256, 257, 129, 200, 200, 0};
		lv = '{256, 256, 128, 57, 56, 5};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ADDR_CTRL, 32'h0000_0008, 1'b0);
		rd(`ADDR_LOOPDIV, 32'h0001_0001, 1'b0);
		rd(`ADDR_STATUS, 32'h0000_0000, 1'b0);
		for (int i = 0; i < 5; i++) rd(`ADDR_CNT_BASE + 12'(4 * i), 32'h0000_0201, 1'b0);
		check({loop_ctrl.fb_mode, loop_ctrl.ref_pin_sel}, {fb_normal, 4'h1});
		rd(12'h00C, 32'h0000_0000, 1'b1);
		rd(12'h006, 32'h0000_0000, 1'b1);
		wr(12'h024, 32'h0000_0201, 1'b1);
		// divide limits for half and other duty settings
		last = 32'h0000_0201;
		for (int i = 0; i < 6; i++) begin
			wr(`ADDR_CNT_BASE + 12'h004, cw(hv[i], lv[i], 0), (i % 2) == 1);
			if ((i % 2) == 0) last = cw(hv[i], lv[i], 0);
			rd(`ADDR_CNT_BASE + 12'h004, last, 1'b0);
		end
		wr(`ADDR_CNT_BASE + 12'h004, cw(300, 0, 0), 1'b1);
		rd(`ADDR_CNT_BASE + 12'h004, last, 1'b0);
		rd(`ADDR_STATUS, 32'h0000_0004, 1'b0);
		// pre-divider and multiplier limits
		wr(`ADDR_LOOPDIV, 32'h0200_0200, 1'b0);
		wr(`ADDR_LOOPDIV, 32'h0001_0000, 1'b1);
		wr(`ADDR_LOOPDIV, 32'h0201_0001, 1'b1);
		check({loop_ctrl.pre_div, loop_ctrl.mult_div}, {10'h200, 10'h200});
		// every feedback mode and reference pin, read one edge after the write lands
		for (int m = 0; m < 6; m++) begin
			wr(`ADDR_CTRL, 32'((m << 2) | ((m % 4) << 5)), m > 4);
			@(posedge pclk);
			if (m < 5) check({loop_ctrl.fb_mode, loop_ctrl.io_path_fb}, {3'(m), m == 0});
			if (m < 5) check(loop_ctrl.ref_pin_sel, 32'(1 << (m % 4)));
		end
		wr(`ADDR_STATUS, 32'h0000_0004, 1'b0);
		// differential run with mixed taps, duty and a one tick start delay on divider four
		wr(`ADDR_CNT_BASE, cw(2, 2, 0), 1'b0);
		wr(`ADDR_CNT_BASE + 12'h004, cw(3, 1, 1), 1'b0);
		wr(`ADDR_CNT_BASE + 12'h008, cw(1, 1, 3), 1'b0);
		wr(`ADDR_CNT_BASE + 12'h00C, cw(1, 1, 0), 1'b0);
		wr(`ADDR_CNT_BASE + 12'h010, 32'h0020_0000 | cw(1, 1, 0), 1'b0);
		wr(`ADDR_CTRL, 32'h0000_0189, 1'b0);
		lock_en <= 1'b1;
		wait_run();
		mon_en <= 1'b1;
		mchk(0, 32, 16);
		mchk(1, 32, 24);
		ochk(3, 2, 3);
		ochk(3, 4, 8);
		check({pos_oe, neg_oe}, 2'b11);
		mon_en <= 1'b0;
		// stop, then halved oscillator, cascade and single-ended output
		wr(`ADDR_CTRL, 32'h0000_0008, 1'b0);
		repeat (4) @(posedge pclk);
		check(gcn, 5'h00);
		wr(`ADDR_CTRL, 32'h0000_0E8B, 1'b0);
		wait_run();
		mchk(0, 64, 32);
		mchk(1, 256, 192);
		check({pos_oe, neg, neg_oe}, 3'b111);
		// lock loss stops every divider together
		lock_en <= 1'b0;
		repeat (12) @(posedge pclk);
		check(gcn, 5'h00);
		rd(`ADDR_STATUS, 32'h0000_0008, 1'b0);
		wr(`ADDR_CTRL, 32'h0000_0008, 1'b0);
		repeat (6) @(posedge pclk);
		rd(`ADDR_STATUS, 32'h0000_0000, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
